// file: hw/nrf_defines.vh
// register map, field positions, reset values and command codes
`ifndef NRF_DEFINES_VH
`define NRF_DEFINES_VH

`define NRF_ADDR_OP_CTRL      6'h00
`define NRF_ADDR_IO_CFG1      6'h04
`define NRF_ADDR_IO_CFG2      6'h08
`define NRF_ADDR_AUX_DEF      6'h0C
`define NRF_ADDR_RFO_NORMAL   6'h10
`define NRF_ADDR_RFO_AM       6'h14
`define NRF_ADDR_AM_DEPTH     6'h18
`define NRF_ADDR_RX_CONF1     6'h1C
`define NRF_ADDR_RX_CONF2     6'h20
`define NRF_ADDR_MASK_TIMER   6'h24
`define NRF_ADDR_WAKE_TIMER   6'h28
`define NRF_ADDR_WAKE_REF     6'h2C
`define NRF_ADDR_RX_RATE      6'h30
`define NRF_ADDR_CMD          6'h34
`define NRF_ADDR_STATUS       6'h38
`define NRF_ADDR_EVENT        6'h3C

`define NRF_OP_OSC_EN         7
`define NRF_OP_RX_EN          6
`define NRF_OP_RX_CHN         5
`define NRF_OP_RX_MAN         4
`define NRF_OP_TX_EN          3
`define NRF_OP_WAKEUP         2

`define NRF_IO1_SINGLE        0
`define NRF_IO1_SECOND        1
`define NRF_IO2_SLOW_UP       0
`define NRF_AUX_AM_SEL        0
`define NRF_AUX_OOK_HZ        1
`define NRF_RX1_AMD_SEL       0
`define NRF_RX1_PM_ONLY       1
`define NRF_RX2_LF_EN         0

`define NRF_EV_OSC            0
`define NRF_EV_WAKE           1
`define NRF_EV_CALIB          2

`define NRF_RST_ZERO          8'h00
`define NRF_RST_RFO_NORMAL    8'hFF
`define NRF_OP_WAKE_ONLY      8'h04

`define NRF_CMD_PRESET        8'h01
`define NRF_CMD_MASK_RX       8'h02
`define NRF_CMD_UNMASK_RX     8'h03
`define NRF_CMD_CALIB_DEPTH   8'h04

`define NRF_RATE_FC8          8'h04

`define NRF_MODE_POWERDOWN    2'h0
`define NRF_MODE_READY        2'h1
`define NRF_MODE_WAKEUP       2'h2

`define NRF_CLK_MHZ           250
`define NRF_TICK_US           1
`define NRF_TICK_CYC          (`NRF_TICK_US * `NRF_CLK_MHZ)
`define NRF_TICK_W            8

`endif

// file: hw/nrf_ctrl.v
// reader mode sequencing, antenna driver and receiver control over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "nrf_defines.vh"

module nrf_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        osc_stable,
  input  wire        mod_active,
  input  wire        tx_done,
  input  wire        framing_pm_pick,
  input  wire        measure_done,
  input  wire [7:0]  measure_value,
  output reg         irq,
  output reg  [1:0]  mode,
  output reg         osc_enable,
  output reg         regulator_enable,
  output reg         rc_osc_enable,
  output reg         measure_req,
  output reg  [7:0]  antenna_driver_a,
  output reg         antenna_driver_a_oen,
  output reg  [7:0]  antenna_driver_b,
  output reg         antenna_driver_b_oen,
  output reg         driver_supply_rail_collapse,
  output reg         driver_supply_rail_ramp,
  output reg         am_channel_on,
  output reg         pm_channel_on,
  output reg         channel_sel_pm,
  output reg         demod_mixer_sel,
  output reg         lf_bypass,
  output reg         rx_window
);

  reg  [7:0] op_ctrl;
  reg  [7:0] io_cfg1;
  reg  [7:0] io_cfg2;
  reg  [7:0] aux_def;
  reg  [7:0] rfo_normal;
  reg  [7:0] rfo_am;
  reg  [7:0] am_depth;
  reg  [7:0] rx_conf1;
  reg  [7:0] rx_conf2;
  reg  [7:0] mask_timer;
  reg  [7:0] wake_timer;
  reg  [7:0] wake_ref;
  reg  [7:0] rx_rate;
  reg  [2:0] events;
  reg  [5:0] bus_addr;
  reg        wr_pend;
  reg        rd_pend;
  reg        osc_seen;
  reg  [7:0] tick_cnt;
  reg        tick;
  reg  [7:0] wake_cnt;
  reg        wake_wait;
  reg  [7:0] mask_cnt;
  reg        mask_run;
  reg  [31:0] read_val;
  reg  [2:0] ev_set;
  reg  [2:0] ev_clr;
  reg  [1:0] next_mode;
  reg  [7:0] seg_level;
  reg        seg_float;

  wire        bus_take = hsel & hready & htrans[1];
  wire        bus_wr = wr_pend & hready;
  wire        cmd_hit = bus_wr & (bus_addr == `NRF_ADDR_CMD);
  wire [7:0]  cmd_val = hwdata[7:0];
  wire [15:0] depth_prod = rfo_normal * (8'hFF - am_depth);
  wire        tx_on = op_ctrl[`NRF_OP_OSC_EN] & op_ctrl[`NRF_OP_TX_EN];
  wire        rx_on_en = op_ctrl[`NRF_OP_OSC_EN] & op_ctrl[`NRF_OP_RX_EN];
  wire        wake_mode = (op_ctrl == `NRF_OP_WAKE_ONLY);
  wire        single = io_cfg1[`NRF_IO1_SINGLE];
  wire        use_b_only = single & io_cfg1[`NRF_IO1_SECOND];
  wire        use_a_only = single & ~io_cfg1[`NRF_IO1_SECOND];
  wire        tick_wrap = (tick_cnt == `NRF_TICK_CYC - 1);
  wire        one_chan = op_ctrl[`NRF_OP_RX_CHN];
  wire        pm_cfg = rx_conf1[`NRF_RX1_PM_ONLY];
  wire        sel_cfg = one_chan | op_ctrl[`NRF_OP_RX_MAN];

  // read mux
  always @*
  begin
    read_val = 32'h0000_0000;
    if (bus_addr == `NRF_ADDR_OP_CTRL)
      read_val[7:0] = op_ctrl;
    else if (bus_addr == `NRF_ADDR_IO_CFG1)
      read_val[7:0] = io_cfg1;
    else if (bus_addr == `NRF_ADDR_IO_CFG2)
      read_val[7:0] = io_cfg2;
    else if (bus_addr == `NRF_ADDR_AUX_DEF)
      read_val[7:0] = aux_def;
    else if (bus_addr == `NRF_ADDR_RFO_NORMAL)
      read_val[7:0] = rfo_normal;
    else if (bus_addr == `NRF_ADDR_RFO_AM)
      read_val[7:0] = rfo_am;
    else if (bus_addr == `NRF_ADDR_AM_DEPTH)
      read_val[7:0] = am_depth;
    else if (bus_addr == `NRF_ADDR_RX_CONF1)
      read_val[7:0] = rx_conf1;
    else if (bus_addr == `NRF_ADDR_RX_CONF2)
      read_val[7:0] = rx_conf2;
    else if (bus_addr == `NRF_ADDR_MASK_TIMER)
      read_val[7:0] = mask_timer;
    else if (bus_addr == `NRF_ADDR_WAKE_TIMER)
      read_val[7:0] = wake_timer;
    else if (bus_addr == `NRF_ADDR_WAKE_REF)
      read_val[7:0] = wake_ref;
    else if (bus_addr == `NRF_ADDR_RX_RATE)
      read_val[7:0] = rx_rate;
    else if (bus_addr == `NRF_ADDR_STATUS)
      read_val[7:0] = {4'h0, rx_window, osc_seen, mode};
    else if (bus_addr == `NRF_ADDR_EVENT)
      read_val[2:0] = events;
  end

  // ahb-lite slave: writes zero-wait, reads one wait state
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_addr <= 6'h00;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= read_val;
    end
    else
    begin
      wr_pend <= bus_take & hwrite;
      rd_pend <= bus_take & ~hwrite;
      hreadyout <= ~(bus_take & ~hwrite);
      if (bus_take)
        bus_addr <= {haddr[5:2], 2'b00};
    end
  end

  // configuration registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_ctrl <= `NRF_RST_ZERO;
      io_cfg1 <= `NRF_RST_ZERO;
      io_cfg2 <= `NRF_RST_ZERO;
      aux_def <= `NRF_RST_ZERO;
      rfo_normal <= `NRF_RST_RFO_NORMAL;
      rfo_am <= `NRF_RST_ZERO;
      am_depth <= `NRF_RST_ZERO;
      rx_conf1 <= `NRF_RST_ZERO;
      rx_conf2 <= `NRF_RST_ZERO;
      mask_timer <= `NRF_RST_ZERO;
      wake_timer <= `NRF_RST_ZERO;
      wake_ref <= `NRF_RST_ZERO;
      rx_rate <= `NRF_RST_ZERO;
    end
    else if (cmd_hit && cmd_val == `NRF_CMD_PRESET)
      rx_conf1[`NRF_RX1_AMD_SEL] <= (rx_rate >= `NRF_RATE_FC8);
    else if (cmd_hit && cmd_val == `NRF_CMD_CALIB_DEPTH)
      rfo_am <= depth_prod[15:8];
    else if (bus_wr)
    begin
      if (bus_addr == `NRF_ADDR_OP_CTRL)
        op_ctrl <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_IO_CFG1)
        io_cfg1 <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_IO_CFG2)
        io_cfg2 <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_AUX_DEF)
        aux_def <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_RFO_NORMAL)
        rfo_normal <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_RFO_AM)
        rfo_am <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_AM_DEPTH)
        am_depth <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_RX_CONF1)
        rx_conf1 <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_RX_CONF2)
        rx_conf2 <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_MASK_TIMER)
        mask_timer <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_WAKE_TIMER)
        wake_timer <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_WAKE_REF)
        wake_ref <= hwdata[7:0];
      else if (bus_addr == `NRF_ADDR_RX_RATE)
        rx_rate <= hwdata[7:0];
    end
  end

  // event flags: set wins over read-clear
  always @*
  begin
    ev_set = 3'h0;
    ev_set[`NRF_EV_OSC] = op_ctrl[`NRF_OP_OSC_EN] & osc_stable & ~osc_seen;
    ev_set[`NRF_EV_WAKE] = wake_mode & wake_wait & measure_done &
                           (measure_value != wake_ref);
    ev_set[`NRF_EV_CALIB] = cmd_hit & (cmd_val == `NRF_CMD_CALIB_DEPTH);
    ev_clr = (rd_pend && bus_addr == `NRF_ADDR_EVENT) ? 3'h7 : 3'h0;
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      events <= 3'h0;
      irq <= 1'b0;
      osc_seen <= 1'b0;
    end
    else
    begin
      events <= ev_set | (events & ~ev_clr);
      irq <= |(ev_set | (events & ~ev_clr));
      osc_seen <= op_ctrl[`NRF_OP_OSC_EN] & (osc_seen | osc_stable);
    end
  end
  // operating mode
  always @*
  begin
    if (op_ctrl[`NRF_OP_OSC_EN])
      next_mode = `NRF_MODE_READY;
    else if (wake_mode)
      next_mode = `NRF_MODE_WAKEUP;
    else
      next_mode = `NRF_MODE_POWERDOWN;
  end
  // microsecond tick and wake-up timer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
      wake_cnt <= 8'h00;
      wake_wait <= 1'b0;
      measure_req <= 1'b0;
    end
    else
    begin
      tick <= tick_wrap;
      tick_cnt <= tick_wrap ? 8'h00 : tick_cnt + 8'h01;
      measure_req <= 1'b0;
      if (!wake_mode)
      begin
        wake_cnt <= 8'h00;
        wake_wait <= 1'b0;
      end
      else if (wake_wait)
        wake_wait <= ~measure_done;
      else if (tick)
      begin
        if (wake_cnt >= wake_timer)
        begin
          wake_cnt <= 8'h00;
          measure_req <= 1'b1;
          wake_wait <= 1'b1;
        end
        else
          wake_cnt <= wake_cnt + 8'h01;
      end
    end
  end
  // receive window and mask timer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_window <= 1'b0;
      mask_cnt <= 8'h00;
      mask_run <= 1'b0;
    end
    else if (!rx_on_en)
    begin
      rx_window <= 1'b0;
      mask_run <= 1'b0;
      mask_cnt <= 8'h00;
    end
    else if (cmd_hit && (cmd_val == `NRF_CMD_MASK_RX ||
                         cmd_val == `NRF_CMD_UNMASK_RX))
    begin
      rx_window <= (cmd_val == `NRF_CMD_UNMASK_RX);
      mask_run <= 1'b0;
    end
    else if (tx_done)
    begin
      rx_window <= 1'b0;
      mask_run <= 1'b1;
      mask_cnt <= 8'h00;
    end
    else if (mask_run && tick)
    begin
      if (mask_cnt >= mask_timer)
      begin
        rx_window <= 1'b1;
        mask_run <= 1'b0;
      end
      else
        mask_cnt <= mask_cnt + 8'h01;
    end
  end
  // driver segment level for the current modulation state
  always @*
  begin
    seg_float = 1'b0;
    if (!mod_active)
      seg_level = rfo_normal;
    else if (aux_def[`NRF_AUX_AM_SEL])
      seg_level = rfo_am;
    else
    begin
      seg_level = 8'h00;
      seg_float = aux_def[`NRF_AUX_OOK_HZ];
    end
  end
  // registered outputs
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode <= `NRF_MODE_POWERDOWN;
      osc_enable <= 1'b0;
      regulator_enable <= 1'b0;
      rc_osc_enable <= 1'b0;
      antenna_driver_a <= 8'h00;
      antenna_driver_a_oen <= 1'b1;
      antenna_driver_b <= 8'h00;
      antenna_driver_b_oen <= 1'b1;
      driver_supply_rail_collapse <= 1'b0;
      driver_supply_rail_ramp <= 1'b0;
      am_channel_on <= 1'b0;
      pm_channel_on <= 1'b0;
      channel_sel_pm <= 1'b0;
      demod_mixer_sel <= 1'b0;
      lf_bypass <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      osc_enable <= op_ctrl[`NRF_OP_OSC_EN];
      regulator_enable <= op_ctrl[`NRF_OP_OSC_EN];
      rc_osc_enable <= wake_mode;
      // unused or idle driver is tristated
      antenna_driver_a <= (tx_on & ~use_b_only) ? seg_level : 8'h00;
      antenna_driver_a_oen <= ~(tx_on & ~use_b_only & ~seg_float);
      antenna_driver_b <= (tx_on & ~use_a_only) ? seg_level : 8'h00;
      antenna_driver_b_oen <= ~(tx_on & ~use_a_only & ~seg_float);
      driver_supply_rail_collapse <= io_cfg2[`NRF_IO2_SLOW_UP] & ~tx_on;
      driver_supply_rail_ramp <= io_cfg2[`NRF_IO2_SLOW_UP] & tx_on;
      am_channel_on <= rx_on_en & ~(one_chan & pm_cfg);
      pm_channel_on <= rx_on_en & (~one_chan | pm_cfg);
      channel_sel_pm <= rx_on_en & (sel_cfg ? pm_cfg : framing_pm_pick);
      demod_mixer_sel <= rx_conf1[`NRF_RX1_AMD_SEL];
      lf_bypass <= rx_conf2[`NRF_RX2_LF_EN];
    end
  end

endmodule
`default_nettype wire

// file: dv/nrf_ctrl_asserts.sv
// port assertions for the reader control block
`timescale 1ns/1ps
`default_nettype none
module nrf_ctrl_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       osc_stable,
  input wire logic       osc_enable,
  input wire logic       regulator_enable,
  input wire logic       irq,
  input wire logic [1:0] mode,
  input wire logic       measure_req,
  input wire logic       rx_window,
  input wire logic [7:0] antenna_driver_a,
  input wire logic       antenna_driver_a_oen,
  input wire logic       driver_supply_rail_collapse,
  input wire logic       driver_supply_rail_ramp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (!hresp)
    else $error("bus response not okay");
  read_wait_a: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait cycle wrong");
  ready_osc_a: assert property (
    mode == 2'h1 |-> osc_enable && regulator_enable)
    else $error("ready mode without oscillator");
  osc_irq_a: assert property (
    osc_enable && $rose(osc_stable) |=> irq)
    else $error("no interrupt on stable oscillator");
  wake_req_a: assert property (
    measure_req |-> mode == 2'h2 ##1 !measure_req)
    else $error("measurement request outside wake mode");
  rxw_off_a: assert property (mode != 2'h1 |-> !rx_window)
    else $error("receive window high with receiver off");
  drv_hiz_a: assert property (
    antenna_driver_a_oen |-> antenna_driver_a == 8'h00)
    else $error("tristated driver carries segments");
  rail_one_a: assert property (
    !(driver_supply_rail_collapse && driver_supply_rail_ramp))
    else $error("rail collapse and ramp together");
endmodule
bind nrf_ctrl nrf_ctrl_chk u_chk (.*);
`default_nettype wire

// file: dv/nrf_afe_model.sv
// front-end model: crystal settling and presence measurement
`timescale 1ns/1ps
`default_nettype none
module nrf_afe_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       osc_enable,
  input  wire logic       measure_req,
  input  wire logic       slow,
  input  wire logic [7:0] level,
  output wire logic       osc_stable,
  output var  logic       measure_done,
  output wire logic [7:0] measure_value
);
  logic [4:0] ocnt;
  logic [4:0] mcnt;
  logic       busy;
  wire  [4:0] lim = slow ? 5'h14 : 5'h02;
  assign osc_stable = osc_enable && ocnt == lim;
  assign measure_value = measure_done ? level : ~level;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ocnt <= 5'h00;
      mcnt <= 5'h00;
      busy <= 1'b0;
      measure_done <= 1'b0;
    end
    else
    begin
      ocnt <= !osc_enable ? 5'h00 : ocnt + {4'h0, ocnt != lim};
      measure_done <= 1'b0;
      if (measure_req)
      begin
        busy <= 1'b1;
        mcnt <= 5'h00;
      end
      else if (busy)
      begin
        mcnt <= mcnt + 5'h01;
        if (mcnt == lim)
        begin
          busy <= 1'b0;
          measure_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/nrf_ctrl_tb.sv
// self-checking bench for the reader control block
`timescale 1ns/1ps
`default_nettype none
`include "nrf_defines.vh"
module nrf_ctrl_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        mod_act = 1'b0;
  logic        tx_done = 1'b0;
  logic        pm_pick = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  level = 8'h00;
  logic [31:0] q;
  wire  [31:0] hrdata;
  wire  [1:0]  mode;
  wire  [7:0]  m_val, dra, drb;
  wire         hreadyout, hresp, osc_st, m_done, irq, osc_en, reg_en, rc_en;
  wire         m_req, oena, oenb, col, ramp, amc, pmc, selpm, mix, lfb, rxw;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [22:0] tt [6] = '{23'h03FDFE, 23'h23FC01, 23'h6003FE, 23'h0C3C1E,
                          23'h040000, 23'h140201};
  logic [12:0] ct [5] = '{13'h180F, 13'h1806, 13'h1C13, 13'h1A0E, 13'h1A17};
  always #2 hclk = ~hclk;
  nrf_ctrl u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .osc_stable(osc_st), .mod_active(mod_act),
    .tx_done(tx_done), .framing_pm_pick(pm_pick), .measure_done(m_done),
    .measure_value(m_val), .irq(irq), .mode(mode), .osc_enable(osc_en),
    .regulator_enable(reg_en), .rc_osc_enable(rc_en), .measure_req(m_req),
    .antenna_driver_a(dra), .antenna_driver_a_oen(oena),
    .antenna_driver_b(drb), .antenna_driver_b_oen(oenb),
    .driver_supply_rail_collapse(col), .driver_supply_rail_ramp(ramp),
    .am_channel_on(amc), .pm_channel_on(pmc), .channel_sel_pm(selpm),
    .demod_mixer_sel(mix), .lf_bypass(lfb), .rx_window(rxw)
  );
  nrf_afe_model u_afe (
    .hclk(hclk), .hresetn(hresetn), .osc_enable(osc_en),
    .measure_req(m_req), .slow(slow), .level(level),
    .osc_stable(osc_st), .measure_done(m_done), .measure_value(m_val)
  );
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string n);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {26'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic r(input logic [5:0] a, input logic [31:0] e,
                   input string n);
    acc(1'b0, a, 8'h00);
    chk(q, e, n);
  endtask
  task automatic t_reset;
    r(`NRF_ADDR_OP_CTRL, 32'h0, "op_ctrl");
    r(`NRF_ADDR_RFO_NORMAL, 32'hFF, "rfo_normal");
    chk({mode, oena, oenb}, 32'h3, "idle");
    chk({hresp, hreadyout}, 32'h1, "bus idle");
    w(`NRF_ADDR_STATUS, 8'hFF);
    r(`NRF_ADDR_STATUS, 32'h0, "status ro");
    $display("t_reset done");
  endtask
  task automatic t_demod;
    chk(mix, 32'h0, "peak dflt");
    for (int i = 3; i < 5; i++)
    begin
      w(`NRF_ADDR_RX_RATE, i[7:0]);
      w(`NRF_ADDR_CMD, `NRF_CMD_PRESET);
      cy(3);
      chk(mix, i / 4, "mixer");
    end
    w(`NRF_ADDR_RX_CONF2, 8'h01);
    cy(3);
    chk(lfb, 32'h1, "lf bypass");
    $display("t_demod done");
  endtask
  task automatic t_ready;
    slow <= 1'b1;
    w(`NRF_ADDR_OP_CTRL, 8'h80);
    for (int i = 0; i < 60 && irq !== 1'b1; i++)
      @(posedge hclk);
    chk({irq, mode, osc_en, reg_en, rc_en}, 32'h2E, "ready");
    r(`NRF_ADDR_EVENT, 32'h1, "osc event");
    r(`NRF_ADDR_STATUS, 32'h5, "status");
    chk(irq, 32'h0, "irq clear");
    $display("t_ready done");
  endtask
  task automatic t_tx;
    w(`NRF_ADDR_OP_CTRL, 8'h88);
    w(`NRF_ADDR_RFO_AM, 8'h0F);
    for (int i = 0; i < 6; i++)
    begin
      w(`NRF_ADDR_IO_CFG1, {6'h0, tt[i][22:21]});
      w(`NRF_ADDR_AUX_DEF, {6'h0, tt[i][20:19]});
      mod_act <= tt[i][18];
      cy(3);
      chk({dra, oena, drb, oenb}, tt[i][17:0], "drivers");
    end
    mod_act <= 1'b0;
    chk(rxw, 32'h0, "rx off");
    w(`NRF_ADDR_AM_DEPTH, 8'h80);
    w(`NRF_ADDR_CMD, `NRF_CMD_CALIB_DEPTH);
    r(`NRF_ADDR_RFO_AM, (32'hFF * (32'hFF - 32'h80)) >> 8, "am lvl");
    r(`NRF_ADDR_EVENT, 32'h4, "calib event");
    $display("t_tx done");
  endtask
  task automatic t_slow;
    w(`NRF_ADDR_OP_CTRL, 8'h80);
    w(`NRF_ADDR_IO_CFG2, 8'h01);
    cy(8);
    chk({col, ramp}, 32'h2, "rail off");
    w(`NRF_ADDR_OP_CTRL, 8'h88);
    cy(3);
    chk({col, ramp}, 32'h1, "rail ramp");
    w(`NRF_ADDR_IO_CFG2, 8'h00);
    $display("t_slow done");
  endtask
  task automatic t_rx;
    w(`NRF_ADDR_OP_CTRL, 8'hC0);
    w(`NRF_ADDR_MASK_TIMER, 8'h02);
    w(`NRF_ADDR_CMD, `NRF_CMD_UNMASK_RX);
    cy(3);
    chk(rxw, 32'h1, "unmask");
    w(`NRF_ADDR_CMD, `NRF_CMD_MASK_RX);
    cy(3);
    chk(rxw, 32'h0, "mask");
    tx_done <= 1'b1;
    @(posedge hclk);
    tx_done <= 1'b0;
    cy(400);
    chk(rxw, 32'h0, "timer run");
    for (int i = 0; i < 400 && rxw !== 1'b1; i++)
      @(posedge hclk);
    chk(rxw, 32'h1, "timer out");
    for (int i = 0; i < 5; i++)
    begin
      w(`NRF_ADDR_OP_CTRL, ct[i][12:5]);
      w(`NRF_ADDR_RX_CONF1, {6'h0, ct[i][4], 1'b0});
      pm_pick <= ct[i][3];
      cy(3);
      chk({amc, pmc, selpm}, ct[i][2:0], "channels");
    end
    w(`NRF_ADDR_OP_CTRL, 8'h80);
    cy(3);
    chk(rxw, 32'h0, "rx disabled");
    $display("t_rx done");
  endtask
  task automatic t_wake;
    w(`NRF_ADDR_OP_CTRL, 8'h00);
    slow <= 1'b0;
    w(`NRF_ADDR_WAKE_TIMER, 8'h00);
    w(`NRF_ADDR_WAKE_REF, 8'h55);
    level <= 8'h55;
    w(`NRF_ADDR_OP_CTRL, 8'h04);
    cy(600);
    chk({mode, rc_en, osc_en, irq}, 32'h14, "wake same");
    level <= 8'h56;
    for (int i = 0; i < 700 && irq !== 1'b1; i++)
      @(posedge hclk);
    chk(irq, 32'h1, "wake irq");
    r(`NRF_ADDR_EVENT, 32'h2, "wake event");
    w(`NRF_ADDR_OP_CTRL, 8'h84);
    cy(3);
    chk({mode, rc_en}, 32'h2, "not wake");
    $display("t_wake done");
  endtask
  initial
  begin
    cy(3);
    hresetn <= 1'b1;
    t_reset();
    t_demod();
    t_ready();
    t_tx();
    t_slow();
    t_rx();
    t_wake();
    summarize();
  end
endmodule
`default_nettype wire
